// File: rtl/axf_pkg.sv
// Package of constants and types for the auxiliary input function logic
package axf_pkg;

   localparam int unsigned NUM_AUX        = 4;
   localparam int unsigned SEL_W          = 3;
   localparam int unsigned ADDR_W         = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_SEL         = 8'h04;
   localparam logic [7:0] OFS_SERIAL      = 8'h08;
   localparam logic [7:0] OFS_STATUS      = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT    = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;

   // Control register fields
   localparam int unsigned CTRL_MANDIS_BIT = 0;
   localparam int unsigned CTRL_OVR_EN_BIT = 1;
   localparam int unsigned CTRL_OVR_LSB    = 4;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

   // Selector register: one 4-bit nibble per input, low 3 bits used
   localparam int unsigned SEL_NIB_W      = 4;
   localparam logic [31:0] SEL_RST        = 32'h0000_1110;

   // Selector codes
   localparam logic [2:0] FN_RUNSTOP      = 3'h0;
   localparam logic [2:0] FN_ALWAYS       = 3'h1;
   localparam logic [2:0] FN_LATCH        = 3'h2;
   localparam logic [2:0] FN_REVERSE      = 3'h3;
   localparam logic [2:0] FN_REVLATCH     = 3'h4;
   localparam logic [2:0] FN_RESET        = 3'h5;
   localparam logic [2:0] SEL_MAX_ONE     = 3'h5;
   localparam logic [2:0] SEL_MAX_OTHER   = 3'h4;

   // Serial field layout
   localparam int unsigned SER_PAR_LSB    = 0;
   localparam int unsigned SER_BAUD_LSB   = 2;
   localparam int unsigned SER_STOP_BIT   = 4;
   localparam logic [1:0] PAR_NONE        = 2'h0;
   localparam logic [1:0] PAR_ODD         = 2'h1;
   localparam logic [1:0] PAR_EVEN        = 2'h2;
   localparam logic [1:0] BAUD_4800       = 2'h0;
   localparam logic [1:0] BAUD_9600       = 2'h1;
   localparam logic [1:0] BAUD_19200      = 2'h2;
   localparam logic [31:0] SER_RST        = 32'h0000_0008;

   // Operating modes requested at the keypad
   localparam logic [1:0] MODE_OFF        = 2'h0;
   localparam logic [1:0] MODE_AUTO       = 2'h1;
   localparam logic [1:0] MODE_MANUAL     = 2'h2;

   // Timing
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned DEBOUNCE_US    = 10_000;
   localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1_000_000 * DEBOUNCE_US;

   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic [1:0] parity;
      logic [1:0] baud;
      logic       two_stop;
   } axf_serial_s;

   typedef struct packed {
      logic       run;
      logic       reverse;
      logic       fault;
      logic       manual_reset;
      logic [1:0] mode;
   } axf_drive_s;

endpackage

// File: rtl/axf_debounce.sv
// Synchroniser and debouncer for one group of contact inputs
`timescale 1ns/1ps
module axf_debounce #(
   parameter int unsigned WIDTH = 4,
   parameter int unsigned COUNT = 400000
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] raw_i,
   output logic      [WIDTH-1:0] clean_o
);

   localparam int unsigned CW = $clog2(COUNT + 1);

   typedef struct packed {
      logic [WIDTH-1:0]         s1;
      logic [WIDTH-1:0]         s2;
      logic [WIDTH-1:0]         clean;
      logic [WIDTH-1:0][CW-1:0] cnt;
   } axf_deb_s;

   axf_deb_s st_reg;
   axf_deb_s st_next;

   if (COUNT < 1) begin : g_bad_count
      $error("COUNT must be at least one");
   end

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = raw_i;
      st_next.s2 = st_reg.s1;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.clean[i]) begin
            st_next.cnt[i] = '0;
         end else if (st_reg.cnt[i] == CW'(COUNT - 1)) begin
            st_next.cnt[i]   = '0;
            st_next.clean[i] = st_reg.s2[i];
         end else begin
            st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign clean_o = st_reg.clean;

endmodule

// File: rtl/axf_aux_input.sv
// Auxiliary contact input function logic with AXI4-Lite registers
`timescale 1ns/1ps
module axf_aux_input #(
   parameter int unsigned DEBOUNCE_CYCLES = axf_pkg::DEBOUNCE_CYC
) (
   input  wire logic                         MCLK_I,
   input  wire logic                         RESETN_I,
   input  wire logic [axf_pkg::NUM_AUX-1:0]  AUX_CLOSED_I,
   input  wire logic                         KEY_CONFIRM_I,
   input  wire logic [1:0]                   KEY_MODE_I,
   input  wire logic [7:0]                   AWADDR_I,
   input  wire logic                         AWVALID_I,
   output logic                              AWREADY_O,
   input  wire logic [31:0]                  WDATA_I,
   input  wire logic [3:0]                   WSTRB_I,
   input  wire logic                         WVALID_I,
   output logic                              WREADY_O,
   output logic [1:0]                        BRESP_O,
   output logic                              BVALID_O,
   input  wire logic                         BREADY_I,
   input  wire logic [7:0]                   ARADDR_I,
   input  wire logic                         ARVALID_I,
   output logic                              ARREADY_O,
   output logic [31:0]                       RDATA_O,
   output logic [1:0]                        RRESP_O,
   output logic                              RVALID_O,
   input  wire logic                         RREADY_I,
   output logic                              MOTOR_RUN_O,
   output logic                              MOTOR_REVERSE_O,
   output logic                              FAULT_O,
   output logic                              MANUAL_RESET_O,
   output logic [1:0]                        OP_MODE_O,
   output logic [1:0]                        SER_PARITY_O,
   output logic [1:0]                        SER_BAUD_O,
   output logic                              SER_TWO_STOP_O,
   output logic                              IRQ_O
);

   localparam int unsigned N = axf_pkg::NUM_AUX;

   typedef struct packed {
      logic [31:0]          ctrl;
      logic [31:0]          sel;
      axf_pkg::axf_serial_s ser;
      logic [7:0]           irq_stat;
      logic [7:0]           irq_mask;
      logic [N-1:0]         latch_flt;
      logic [N-1:0]         prev;
      logic                 key_s1;
      logic                 key_s2;
      logic                 key_prev;
      logic [1:0]           mode_s1;
      logic [1:0]           mode_s2;
      logic                 reset_armed;
      axf_pkg::axf_drive_s  drv;
      logic                 irq;
      logic                 aw_have;
      logic [7:0]           aw_addr;
      logic                 w_have;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [2:0]           rdy;
   } axf_state_s;

   axf_state_s       st_reg;
   axf_state_s       st_next;
   logic [N-1:0]     aux_clean;
   logic [N-1:0][2:0] fn;

   if (N != 4) begin : g_bad_n
      $error("Block is built for exactly four auxiliary inputs");
   end

   axf_debounce #(
      .WIDTH (N),
      .COUNT (DEBOUNCE_CYCLES)
   ) u_deb (
      .clk_i    (MCLK_I),
      .resetn_i (RESETN_I),
      .raw_i    (AUX_CLOSED_I),
      .clean_o  (aux_clean)
   );

   generate
      for (genvar g = 0; g < N; g++) begin : g_fn
         assign fn[g] = st_reg.ctrl[axf_pkg::CTRL_OVR_EN_BIT]
                        ? st_reg.ctrl[axf_pkg::CTRL_OVR_LSB + g*4 +: 3]
                        : st_reg.sel[g*4 +: 3];
      end
   endgenerate

   always_comb begin
      logic         run;
      logic         rev;
      logic         key_press;
      logic         man_reset;
      logic [7:0]   ev;
      logic [31:0]  wmask;
      logic [31:0]  wval;
      logic [31:0]  rd;
      logic         do_wr;
      logic         hit;
      logic [2:0]   nv;
      run       = 1'b1;
      rev       = 1'b0;
      man_reset = 1'b0;
      ev        = '0;
      wmask     = '0;
      wval      = '0;
      rd        = '0;
      hit       = 1'b0;
      nv        = '0;
      key_press = st_reg.key_s2 & ~st_reg.key_prev;
      do_wr     = st_reg.aw_have & st_reg.w_have;
      st_next   = st_reg;

      st_next.key_s1   = KEY_CONFIRM_I;
      st_next.key_s2   = st_reg.key_s1;
      st_next.key_prev = st_reg.key_s2;
      st_next.mode_s1  = KEY_MODE_I;
      st_next.mode_s2  = st_reg.mode_s1;
      st_next.prev     = aux_clean;

      for (int i = 0; i < N; i++) begin
         case (fn[i])
            axf_pkg::FN_RUNSTOP: run = run & aux_clean[i];
            axf_pkg::FN_ALWAYS: run = run;
            axf_pkg::FN_LATCH: begin
               if (!aux_clean[i] && st_reg.prev[i]) begin
                  st_next.latch_flt[i] = 1'b1;
                  ev[i] = 1'b1;
               end
            end
            axf_pkg::FN_REVERSE: begin
               // each closed input toggles reverse, input one disabled
               if (i != 0) begin
                  rev = rev ^ aux_clean[i];
               end
            end
            axf_pkg::FN_REVLATCH: begin
               if (aux_clean[i] && !st_reg.prev[i]) begin
                  st_next.latch_flt[i] = 1'b1;
                  ev[i] = 1'b1;
               end
            end
            axf_pkg::FN_RESET: begin
               if (i == 0) begin
                  if (!aux_clean[i]) begin
                     st_next.reset_armed = 1'b1;
                  end else if (st_reg.reset_armed) begin
                     st_next.reset_armed = 1'b0;
                     man_reset = 1'b1;
                     ev[4] = 1'b1;
                  end
               end
            end
            default: run = run;
         endcase
      end

      // confirm key clears latched faults; new event wins
      if (key_press || man_reset) begin
         st_next.latch_flt = st_next.latch_flt & ev[N-1:0];
      end
      if (key_press) begin
         ev[5] = 1'b1;
      end

      st_next.drv.run          = run & ~(|st_next.latch_flt);
      st_next.drv.reverse      = rev;
      st_next.drv.fault        = |st_next.latch_flt;
      st_next.drv.manual_reset = man_reset;
      if (st_reg.mode_s2 == axf_pkg::MODE_MANUAL && st_reg.ctrl[axf_pkg::CTRL_MANDIS_BIT]) begin
         st_next.drv.mode = axf_pkg::MODE_OFF;
      end else begin
         st_next.drv.mode = st_reg.mode_s2;
      end

      // AXI4-Lite write channel capture
      if (AWVALID_I && !st_reg.aw_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = AWADDR_I;
      end
      if (WVALID_I && !st_reg.w_have && !st_reg.bvalid) begin
         st_next.w_have = 1'b1;
         st_next.w_data = WDATA_I;
         st_next.w_strb = WSTRB_I;
      end
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{st_reg.w_strb[b]}};
      end
      if (do_wr) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = axf_pkg::RESP_OKAY;
         case (st_reg.aw_addr)
            axf_pkg::OFS_CTRL: begin
               st_next.ctrl = (st_reg.ctrl & ~wmask) | (st_reg.w_data & wmask);
            end
            axf_pkg::OFS_SEL: begin
               wval = (st_reg.sel & ~wmask) | (st_reg.w_data & wmask);
               // out of range selector keeps old value
               for (int i = 0; i < N; i++) begin
                  nv = wval[i*4 +: 3];
                  if (nv <= ((i == 0) ? axf_pkg::SEL_MAX_ONE : axf_pkg::SEL_MAX_OTHER)) begin
                     st_next.sel[i*4 +: 3] = nv;
                  end
               end
            end
            axf_pkg::OFS_SERIAL: begin
               if (st_reg.w_strb[0]) begin
                  if (st_reg.w_data[axf_pkg::SER_PAR_LSB +: 2] <= axf_pkg::PAR_EVEN) begin
                     st_next.ser.parity = st_reg.w_data[axf_pkg::SER_PAR_LSB +: 2];
                  end
                  if (st_reg.w_data[axf_pkg::SER_BAUD_LSB +: 2] <= axf_pkg::BAUD_19200) begin
                     st_next.ser.baud = st_reg.w_data[axf_pkg::SER_BAUD_LSB +: 2];
                  end
                  st_next.ser.two_stop = st_reg.w_data[axf_pkg::SER_STOP_BIT];
               end
            end
            axf_pkg::OFS_STATUS: st_next.bresp = axf_pkg::RESP_OKAY;
            axf_pkg::OFS_IRQ_STAT: begin
               st_next.irq_stat = st_reg.irq_stat & ~(st_reg.w_data[7:0] & wmask[7:0]);
            end
            axf_pkg::OFS_IRQ_MASK: begin
               st_next.irq_mask = st_reg.w_strb[0] ? st_reg.w_data[7:0] : st_reg.irq_mask;
            end
            default: st_next.bresp = axf_pkg::RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && BREADY_I) begin
         st_next.bvalid = 1'b0;
      end

      // Sticky events: set wins over clear
      st_next.irq_stat = st_next.irq_stat | ev;
      st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

      // AXI4-Lite read channel
      if (ARVALID_I && !st_reg.rvalid) begin
         hit = 1'b1;
         case (ARADDR_I)
            axf_pkg::OFS_CTRL:     rd = st_reg.ctrl;
            axf_pkg::OFS_SEL:      rd = st_reg.sel;
            axf_pkg::OFS_SERIAL: begin
               rd[axf_pkg::SER_PAR_LSB +: 2]  = st_reg.ser.parity;
               rd[axf_pkg::SER_BAUD_LSB +: 2] = st_reg.ser.baud;
               rd[axf_pkg::SER_STOP_BIT]      = st_reg.ser.two_stop;
            end
            axf_pkg::OFS_STATUS: begin
               rd[N-1:0]   = aux_clean;
               rd[7:4]     = st_reg.latch_flt;
               rd[8]       = st_reg.drv.run;
               rd[9]       = st_reg.drv.reverse;
               rd[10]      = st_reg.drv.fault;
               rd[13:12]   = st_reg.drv.mode;
            end
            axf_pkg::OFS_IRQ_STAT: rd[7:0] = st_reg.irq_stat;
            axf_pkg::OFS_IRQ_MASK: rd[7:0] = st_reg.irq_mask;
            default:               hit = 1'b0;
         endcase
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd;
         st_next.rresp  = hit ? axf_pkg::RESP_OKAY : axf_pkg::RESP_SLVERR;
      end else if (st_reg.rvalid && RREADY_I) begin
         st_next.rvalid = 1'b0;
      end
      st_next.rdy = {~(st_next.aw_have | st_next.bvalid), ~(st_next.w_have | st_next.bvalid),
                     ~st_next.rvalid};
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESETN_I) begin
         st_reg               <= '0;
         st_reg.rdy           <= '1;
         st_reg.ctrl          <= axf_pkg::CTRL_RST;
         st_reg.sel           <= axf_pkg::SEL_RST;
         st_reg.ser.parity    <= axf_pkg::PAR_NONE;
         st_reg.ser.baud      <= axf_pkg::BAUD_19200;
         st_reg.ser.two_stop  <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign AWREADY_O       = st_reg.rdy[2];
   assign WREADY_O        = st_reg.rdy[1];
   assign BVALID_O        = st_reg.bvalid;
   assign BRESP_O         = st_reg.bresp;
   assign ARREADY_O       = st_reg.rdy[0];
   assign RVALID_O        = st_reg.rvalid;
   assign RDATA_O         = st_reg.rdata;
   assign RRESP_O         = st_reg.rresp;
   assign MOTOR_RUN_O     = st_reg.drv.run;
   assign MOTOR_REVERSE_O = st_reg.drv.reverse;
   assign FAULT_O         = st_reg.drv.fault;
   assign MANUAL_RESET_O  = st_reg.drv.manual_reset;
   assign OP_MODE_O       = st_reg.drv.mode;
   assign SER_PARITY_O    = st_reg.ser.parity;
   assign SER_BAUD_O      = st_reg.ser.baud;
   assign SER_TWO_STOP_O  = st_reg.ser.two_stop;
   assign IRQ_O           = st_reg.irq;

endmodule

// File: sim/axf_contact_model.sv
// Behavioural dry-contact switches with contact bounce
`timescale 1ns/1ps
module axf_contact_model (
   input  wire logic       clk_i,
   input  wire logic [3:0] cmd_i,
   output logic      [3:0] closed_o
);
   logic [3:0] prev_reg = 4'h0;
   logic [3:0] chg_reg  = 4'h0;
   logic [1:0] cnt_reg  = 2'h0;

   initial closed_o = 4'h0;

   // Changed contacts chatter for a few cycles before settling
   always @(posedge clk_i) begin
      prev_reg <= cmd_i;
      if (cmd_i != prev_reg) begin
         chg_reg <= cmd_i ^ prev_reg;
         cnt_reg <= 2'h3;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
      closed_o <= cnt_reg[0] ? (cmd_i ^ chg_reg) : cmd_i;
   end
endmodule

// File: sim/axf_aux_input_checker.sv
// Port-level assertions for the auxiliary input function block
`timescale 1ns/1ps
module axf_aux_input_checker (
   input wire logic       MCLK_I,
   input wire logic       RESETN_I,
   input wire logic       AWVALID_I,
   input wire logic       AWREADY_O,
   input wire logic       WVALID_I,
   input wire logic       WREADY_O,
   input wire logic       BVALID_O,
   input wire logic       ARVALID_I,
   input wire logic       ARREADY_O,
   input wire logic       RVALID_O,
   input wire logic       MOTOR_RUN_O,
   input wire logic       FAULT_O,
   input wire logic       MANUAL_RESET_O,
   input wire logic [1:0] OP_MODE_O,
   input wire logic [1:0] SER_PARITY_O,
   input wire logic [1:0] SER_BAUD_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_wr_taken;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence

   sequence s_rd_taken;
      ARVALID_I && ARREADY_O;
   endsequence

   a_wr_answer: assert property (s_wr_taken |-> ##2 BVALID_O)
      else $error("write response not on time");
   a_wr_refuse: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write accepted while response pending");
   a_rd_answer: assert property (s_rd_taken |=> RVALID_O)
      else $error("read data not on time");
   a_rd_refuse: assert property (RVALID_O |-> !ARREADY_O)
      else $error("read accepted while data pending");
   a_fault_stops: assert property (FAULT_O && $past(FAULT_O) |-> !MOTOR_RUN_O)
      else $error("motor runs with latched fault");
   a_reset_pulse: assert property (MANUAL_RESET_O |=> !MANUAL_RESET_O)
      else $error("manual reset pulse too long");
   a_mode_legal: assert property (OP_MODE_O != 2'h3)
      else $error("illegal operating mode");
   a_parity_legal: assert property (SER_PARITY_O != 2'h3)
      else $error("illegal parity code");
   a_baud_legal: assert property (SER_BAUD_O != 2'h3)
      else $error("illegal baud code");
endmodule

bind axf_aux_input axf_aux_input_checker i_chk (.MCLK_I, .RESETN_I, .AWVALID_I, .AWREADY_O,
   .WVALID_I, .WREADY_O, .BVALID_O, .ARVALID_I, .ARREADY_O, .RVALID_O, .MOTOR_RUN_O,
   .FAULT_O, .MANUAL_RESET_O, .OP_MODE_O, .SER_PARITY_O, .SER_BAUD_O);

// File: sim/axf_aux_input_tb_top.sv
// Self-checking bench for the auxiliary input function block
`timescale 1ns/1ps
module axf_aux_input_tb_top;
   logic        mclk;
   logic        resetn   = 1'b0;
   logic        key_conf = 1'b0;
   logic [1:0]  key_mode = 2'h0;
   logic [3:0]  cmd      = 4'h0;
   logic [7:0]  awaddr   = 8'h00;
   logic [7:0]  araddr   = 8'h00;
   logic [31:0] wdata    = 32'h0;
   logic        awvalid  = 1'b0;
   logic        wvalid   = 1'b0;
   logic        bready   = 1'b0;
   logic        arvalid  = 1'b0;
   logic        rready   = 1'b0;
   logic        seen     = 1'b0;
   logic [3:0]  aux;
   logic [1:0]  bresp, rresp, mode, par, baud;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, run, rev, fault, mrst, stop2, irq;
   int          n_errors = 0;
   int          n_tests  = 0;

   axf_contact_model i_sw (.clk_i(mclk), .cmd_i(cmd), .closed_o(aux));
   axf_aux_input #(.DEBOUNCE_CYCLES(4)) i_dut (
      .MCLK_I(mclk), .RESETN_I(resetn), .AUX_CLOSED_I(aux), .KEY_CONFIRM_I(key_conf),
      .KEY_MODE_I(key_mode), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
      .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .MOTOR_RUN_O(run), .MOTOR_REVERSE_O(rev), .FAULT_O(fault),
      .MANUAL_RESET_O(mrst), .OP_MODE_O(mode), .SER_PARITY_O(par), .SER_BAUD_O(baud),
      .SER_TWO_STOP_O(stop2), .IRQ_O(irq));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (mrst === 1'b1) seen <= 1'b1;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Flags in order run, reverse, fault, interrupt
   task automatic ck_out(input logic [3:0] e);
      chk(32'({run, rev, fault, irq}), 32'(e));
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
      repeat (2) @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk(32'(rresp), 32'(er));
   endtask

   task automatic sw(input logic [3:0] v);
      @(posedge mclk);
      cmd <= v;
      repeat (24) @(posedge mclk);
   endtask

   task automatic confirm;
      @(posedge mclk);
      key_conf <= 1'b1;
      repeat (4) @(posedge mclk);
      key_conf <= 1'b0;
      repeat (24) @(posedge mclk);
   endtask

   task automatic t_reset;
      rd(axf_pkg::OFS_SEL, axf_pkg::SEL_RST, axf_pkg::RESP_OKAY);
      rd(axf_pkg::OFS_SERIAL, axf_pkg::SER_RST, axf_pkg::RESP_OKAY);
      rd(axf_pkg::OFS_CTRL, axf_pkg::CTRL_RST, axf_pkg::RESP_OKAY);
      wr(axf_pkg::OFS_SEL, 32'h0000_5555, axf_pkg::RESP_OKAY);
      rd(axf_pkg::OFS_SEL, 32'h0000_1115, axf_pkg::RESP_OKAY);
      rd(8'h20, 32'h0, axf_pkg::RESP_SLVERR);
      wr(8'h24, 32'hFFFF_FFFF, axf_pkg::RESP_SLVERR);
      $display("done reset and map");
   endtask

   task automatic t_serial;
      for (int p = 0; p < 3; p++) begin
         wr(axf_pkg::OFS_SERIAL, 32'h10 | 32'(p * 5), axf_pkg::RESP_OKAY);
         chk(32'({par, baud, stop2}), 32'(p * 10 + 1));
      end
      wr(axf_pkg::OFS_SERIAL, 32'h0F, axf_pkg::RESP_OKAY);
      chk(32'({par, baud, stop2}), 32'd20);
      $display("done serial");
   endtask

   task automatic t_latch;
      wr(axf_pkg::OFS_SEL, 32'h1110, axf_pkg::RESP_OKAY);
      sw(4'hE);
      ck_out(4'h0);
      sw(4'h1);
      ck_out(4'h8);
      wr(axf_pkg::OFS_IRQ_MASK, 32'h2, axf_pkg::RESP_OKAY);
      wr(axf_pkg::OFS_SEL, 32'h1120, axf_pkg::RESP_OKAY);
      sw(4'h3);
      ck_out(4'h8);
      sw(4'h1);
      ck_out(4'h3);
      sw(4'h3);
      ck_out(4'h3);
      confirm();
      ck_out(4'h9);
      wr(axf_pkg::OFS_IRQ_MASK, 32'h0, axf_pkg::RESP_OKAY);
      ck_out(4'h8);
      wr(axf_pkg::OFS_IRQ_MASK, 32'h2, axf_pkg::RESP_OKAY);
      ck_out(4'h9);
      wr(axf_pkg::OFS_IRQ_STAT, 32'h2, axf_pkg::RESP_OKAY);
      ck_out(4'h8);
      $display("done run and latch");
   endtask

   task automatic t_revlatch;
      wr(axf_pkg::OFS_SEL, 32'h1140, axf_pkg::RESP_OKAY);
      sw(4'h1);
      ck_out(4'h8);
      sw(4'h3);
      ck_out(4'h3);
      sw(4'h1);
      ck_out(4'h3);
      confirm();
      ck_out(4'h9);
      wr(axf_pkg::OFS_IRQ_STAT, 32'h2, axf_pkg::RESP_OKAY);
      wr(axf_pkg::OFS_IRQ_MASK, 32'h0, axf_pkg::RESP_OKAY);
      $display("done reverse latch");
   endtask

   task automatic t_reverse;
      wr(axf_pkg::OFS_SEL, 32'h1133, axf_pkg::RESP_OKAY);
      sw(4'h0);
      ck_out(4'h8);
      sw(4'h2);
      ck_out(4'hC);
      sw(4'h3);
      ck_out(4'hC);
      wr(axf_pkg::OFS_SEL, 32'h1110, axf_pkg::RESP_OKAY);
      wr(axf_pkg::OFS_CTRL, 32'h0001_1302, axf_pkg::RESP_OKAY);
      sw(4'h2);
      ck_out(4'h4);
      wr(axf_pkg::OFS_CTRL, 32'h0, axf_pkg::RESP_OKAY);
      ck_out(4'h0);
      $display("done reverse");
   endtask

   task automatic t_manrst;
      wr(axf_pkg::OFS_SEL, 32'h1125, axf_pkg::RESP_OKAY);
      sw(4'h3);
      sw(4'h1);
      ck_out(4'h2);
      sw(4'h0);
      seen <= 1'b0;
      ck_out(4'h2);
      sw(4'h1);
      ck_out(4'h8);
      chk(32'(seen), 32'h1);
      $display("done manual reset");
   endtask

   task automatic t_mode;
      key_mode <= axf_pkg::MODE_MANUAL;
      repeat (8) @(posedge mclk);
      chk(32'(mode), 32'(axf_pkg::MODE_MANUAL));
      wr(axf_pkg::OFS_CTRL, 32'h1, axf_pkg::RESP_OKAY);
      chk(32'(mode), 32'(axf_pkg::MODE_OFF));
      key_mode <= axf_pkg::MODE_AUTO;
      repeat (8) @(posedge mclk);
      chk(32'(mode), 32'(axf_pkg::MODE_AUTO));
      $display("done mode");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_serial();
      t_latch();
      t_revlatch();
      t_reverse();
      t_manrst();
      t_mode();
      test_done();
   end
endmodule
